// [logic/pcis_cfg.svh]
// Register offsets, field positions and reset values of the input status block.
// Assumes inclusion by bare name from the design module.
`ifndef PCIS_CFG_SVH
`define PCIS_CFG_SVH
`define PCIS_ADDR_STATUS 8'hC1
`define PCIS_ADDR_THRESH 8'hE4
`define PCIS_THRESH_RESET 8'h01
`define PCIS_STATUS_RESET 8'h00
`define PCIS_TH_HI_MSB 7
`define PCIS_TH_HI_LSB 6
`define PCIS_TH_LO_MSB 5
`define PCIS_TH_LO_LSB 4
`define PCIS_TH_FORCE_PULLDOWN 3
`define PCIS_TH_PUP 2
`define PCIS_TH_READ_VALID 0
`define PCIS_MODE_OFF 2'h0
`define PCIS_MODE_QUAD 2'h3
`endif

// [logic/pcis_pkg.sv]
// Types shared by the input status block.
// Assumes nothing beyond the constants header.
package pcis_pkg;
    // Quadrature position, first bit input 1, second bit input 0
    typedef enum logic [1:0] {
        PCIS_LL = 2'b00,
        PCIS_LH = 2'b01,
        PCIS_HH = 2'b11,
        PCIS_HL = 2'b10
    } pcis_quad_t;
endpackage : pcis_pkg

// [logic/pcis_status.sv]
// Input conditioning and status of a two-input pulse counter.
// Assumes one slow sample clock; comparator outputs arrive from pins.
`include "pcis_cfg.svh"

module pcis_status
    import pcis_pkg::*;
#(
    parameter int DEB_W = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic rt_other_read,
    input wire logic rt_update,
    input wire logic [1:0] comparator_in,
    input wire logic [1:0] counter_mode_select,
    input wire logic [DEB_W-1:0] high_debounce_count,
    input wire logic [DEB_W-1:0] low_debounce_count,
    input wire logic pullup_duty_phase,
    output logic [1:0] high_threshold_select,
    output logic [1:0] low_threshold_select,
    output logic pulldown_on,
    output logic pullup_on,
    output logic [1:0] integrator_out
);

    localparam int CW = DEB_W + 1;

    // Configuration register fields
    logic [1:0] th_hi;
    logic [1:0] th_lo;
    logic force_pulldown;
    logic force_pullup;
    logic read_valid;
    logic [1:0] next_th_hi;
    logic [1:0] next_th_lo;
    logic next_force_pulldown;
    logic next_force_pullup;
    logic next_read_valid;

    // Register bus decode; reads of the other real-time registers arrive as a strobe
    // from the block that owns them, so one flag covers all six
    logic wr_th;
    logic rd_th;
    logic rd_stat;
    logic rt_read;
    assign wr_th = sfr_wr && (sfr_addr == `PCIS_ADDR_THRESH);
    assign rd_th = sfr_rd && (sfr_addr == `PCIS_ADDR_THRESH);
    assign rd_stat = sfr_rd && (sfr_addr == `PCIS_ADDR_STATUS);
    assign rt_read = rd_stat || rt_other_read;

    // Configuration next values; a torn read beats the self-restore on read
    always_comb begin
        next_th_hi = th_hi;
        next_th_lo = th_lo;
        next_force_pulldown = force_pulldown;
        next_force_pullup = force_pullup;
        next_read_valid = read_valid;
        if (wr_th) begin
            next_th_hi = sfr_wdata[`PCIS_TH_HI_MSB:`PCIS_TH_HI_LSB];
            next_th_lo = sfr_wdata[`PCIS_TH_LO_MSB:`PCIS_TH_LO_LSB];
            next_force_pulldown = sfr_wdata[`PCIS_TH_FORCE_PULLDOWN];
            next_force_pullup = sfr_wdata[`PCIS_TH_PUP];
        end
        if (rd_th) begin
            next_read_valid = 1'b1;
        end
        if (rt_read && rt_update) begin
            next_read_valid = 1'b0;
        end
    end

    // Configuration register; every field resets from the one constant
    // so the fields and the documented reset value cannot drift apart
    always_ff @(posedge clock) begin
        if (reset) begin
            th_hi <= 2'(`PCIS_THRESH_RESET >> `PCIS_TH_HI_LSB);
            th_lo <= 2'(`PCIS_THRESH_RESET >> `PCIS_TH_LO_LSB);
            force_pulldown <= 1'(`PCIS_THRESH_RESET >> `PCIS_TH_FORCE_PULLDOWN);
            force_pullup <= 1'(`PCIS_THRESH_RESET >> `PCIS_TH_PUP);
            read_valid <= 1'(`PCIS_THRESH_RESET >> `PCIS_TH_READ_VALID);
        end else begin
            th_hi <= next_th_hi;
            th_lo <= next_th_lo;
            force_pulldown <= next_force_pulldown;
            force_pullup <= next_force_pullup;
            read_valid <= next_read_valid;
        end
    end

    // Comparator codes go straight to the analog trims
    assign high_threshold_select = th_hi;
    assign low_threshold_select = th_lo;

    // Pull control; pull-down wins so the pad never fights itself
    assign pulldown_on = force_pulldown;
    assign pullup_on = !force_pulldown && (force_pullup || pullup_duty_phase);

    // Mode decode; any non-zero mode runs the integrators,
    // while only code 11 tracks direction and flutter
    logic enabled;
    logic quad;
    assign enabled = counter_mode_select != `PCIS_MODE_OFF;
    assign quad = counter_mode_select == `PCIS_MODE_QUAD;

    // Per input: pin synchroniser, agreement filter and integrator
    logic [1:0] cur;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            logic out;
            logic [CW-1:0] cnt;
            logic next_lvl;
            logic next_out;
            logic [CW-1:0] next_cnt;
            logic [CW-1:0] limit;

            // Debounce target is the programmed value plus one; the counter is one bit
            // wider than the setting so an all-ones value still has room to reach it.
            // A bouncing pin only delays the flip, it never flips the output early
            always_comb begin
                next_lvl = (s2 == s3) ? s3 : lvl;
                next_out = out;
                next_cnt = cnt;
                limit = out ? CW'(low_debounce_count) + CW'(1)
                            : CW'(high_debounce_count) + CW'(1);
                if (!enabled) begin
                    next_cnt = '0;
                end else if (lvl != out) begin
                    next_cnt = cnt + CW'(1);
                    if (next_cnt >= limit) begin
                        next_out = lvl;
                        next_cnt = '0;
                    end
                end else if (cnt != '0) begin
                    next_cnt = cnt - CW'(1);
                end
            end

            // Synchroniser, agreement filter and integrator registers
            always_ff @(posedge clock) begin
                if (reset) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    lvl <= 1'b0;
                    out <= 1'b0;
                    cnt <= '0;
                end else begin
                    s1 <= comparator_in[gi];
                    s2 <= s1;
                    s3 <= s2;
                    lvl <= next_lvl;
                    out <= next_out;
                    cnt <= next_cnt;
                end
            end

            assign cur[gi] = out;
        end
    endgenerate

    assign integrator_out = cur;

    // Counting state machine and quadrature tracking
    // The state is the last accepted position, so it moves only while counting
    pcis_quad_t state;
    pcis_quad_t next_state;
    logic [1:0] prev;
    logic [1:0] next_prev;
    logic dir;
    logic next_dir;
    logic flutter;
    logic next_flutter;
    logic signed [2:0] fall_diff;
    logic signed [2:0] rise_diff;
    logic signed [2:0] next_fall_diff;
    logic signed [2:0] next_rise_diff;
    logic [1:0] rise;
    logic [1:0] fall;
    pcis_quad_t seen;

    assign rise = cur & ~prev;
    assign fall = ~cur & prev;
    assign seen = pcis_quad_t'(cur);

    // Step of one position in the counter clockwise order
    function automatic pcis_quad_t ccw_step(input pcis_quad_t s);
        unique case (s)
            PCIS_LL: ccw_step = PCIS_LH;
            PCIS_LH: ccw_step = PCIS_HH;
            PCIS_HH: ccw_step = PCIS_HL;
            PCIS_HL: ccw_step = PCIS_LL;
        endcase
    endfunction : ccw_step

    // Edge imbalance of one beyond the normal lead means flutter. In a clean turn one
    // input always leads the other by a single edge, so a lead of two cannot be motion.
    // The flag stays set until quadrature is left, so a short burst is not missed
    always_comb begin
        next_prev = cur;
        next_state = enabled ? seen : state;
        next_dir = dir;
        next_flutter = flutter;
        next_fall_diff = fall_diff;
        next_rise_diff = rise_diff;
        if (!quad) begin
            next_flutter = 1'b0;
            next_fall_diff = 3'sd0;
            next_rise_diff = 3'sd0;
        end else begin
            if (seen == ccw_step(state)) begin
                next_dir = 1'b0;
            end else if (state == ccw_step(seen)) begin
                next_dir = 1'b1;
            end
            if (fall[1] && !fall[0] && fall_diff != 3'sd3) begin
                next_fall_diff = fall_diff + 3'sd1;
            end else if (fall[0] && !fall[1] && fall_diff != -3'sd3) begin
                next_fall_diff = fall_diff - 3'sd1;
            end
            if (rise[1] && !rise[0] && rise_diff != 3'sd3) begin
                next_rise_diff = rise_diff + 3'sd1;
            end else if (rise[0] && !rise[1] && rise_diff != -3'sd3) begin
                next_rise_diff = rise_diff - 3'sd1;
            end
            if (next_fall_diff > 3'sd1 || next_fall_diff < -3'sd1 ||
                next_rise_diff > 3'sd1 || next_rise_diff < -3'sd1) begin
                next_flutter = 1'b1;
            end
        end
    end

    // Quadrature tracking registers
    always_ff @(posedge clock) begin
        if (reset) begin
            prev <= 2'h0;
            state <= PCIS_LL;
            dir <= 1'b0;
            flutter <= 1'b0;
            fall_diff <= 3'sd0;
            rise_diff <= 3'sd0;
        end else begin
            prev <= next_prev;
            state <= next_state;
            dir <= next_dir;
            flutter <= next_flutter;
            fall_diff <= next_fall_diff;
            rise_diff <= next_rise_diff;
        end
    end

    // Read data; status view is live so software sees the last sample
    logic [7:0] status_view;
    logic [7:0] thresh_view;
    logic [7:0] next_rdata;
    assign status_view = {flutter, dir, state, prev, cur};
    assign thresh_view = {th_hi, th_lo, force_pulldown, force_pullup,
                          1'b0, read_valid};

    always_comb begin
        next_rdata = 8'h00;
        if (rd_stat) begin
            next_rdata = status_view;
        end else if (rd_th) begin
            next_rdata = thresh_view;
        end
    end

    // Read data is registered and stands for one cycle, zero otherwise,
    // so a stale value never lingers on the shared data bus
    always_ff @(posedge clock) begin
        if (reset) begin
            sfr_rdata <= `PCIS_STATUS_RESET;
        end else begin
            sfr_rdata <= next_rdata;
        end
    end

endmodule : pcis_status

// [testbench/pcis_status_sva.sv]
// Port checker for the input status block.
// Assumes read data answers one cycle after the read strobe edge.
module pcis_status_sva
    import pcis_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic rt_other_read,
    input wire logic rt_update,
    input wire logic [1:0] high_threshold_select,
    input wire logic [1:0] low_threshold_select,
    input wire logic pulldown_on,
    input wire logic pullup_on,
    input wire logic [1:0] integrator_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Decoded accesses
    wire logic wr_th = sfr_wr && sfr_addr == 8'hE4;
    wire logic rd_th = sfr_rd && sfr_addr == 8'hE4;
    wire logic rd_st = sfr_rd && sfr_addr == 8'hC1;
    a_hi_thresh: assert property (wr_th |=> high_threshold_select == $past(sfr_wdata[7:6]))
        else $error("high select wrong");
    a_lo_thresh: assert property (wr_th |=> low_threshold_select == $past(sfr_wdata[5:4]))
        else $error("low select wrong");
    a_force_pulldown_write: assert property (wr_th |=> pulldown_on == $past(sfr_wdata[3]))
        else $error("pull-down wrong");
    a_pup_forced: assert property (wr_th && sfr_wdata[3:2] == 2'h1 |=> pullup_on)
        else $error("pull-up not forced");
    a_pull_prec: assert property (pulldown_on |-> !pullup_on)
        else $error("pull-up beside pull-down");
    a_reserved_zero: assert property (rd_th |=> !sfr_rdata[1])
        else $error("reserved bit set");
    a_rv_restore: assert property (rd_th && !rt_update ##1 !rt_update ##1 rd_th |=> sfr_rdata[0])
        else $error("read valid not restored");
    a_rv_clear: assert property ((rd_st || rt_other_read) && rt_update ##1
        !rt_update && !rd_th ##1 rd_th |=> !sfr_rdata[0]) else $error("read valid not cleared");
    a_stat_now: assert property (rd_st |=> sfr_rdata[1:0] == $past(integrator_out))
        else $error("current outputs wrong");
    a_stat_prev: assert property (rd_st |=> sfr_rdata[3:2] == $past(integrator_out, 2))
        else $error("previous outputs wrong");
endmodule : pcis_status_sva
bind pcis_status pcis_status_sva chk (.clock, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .rt_other_read, .rt_update, .high_threshold_select, .low_threshold_select,
    .pulldown_on, .pullup_on, .integrator_out);

// [testbench/pcis_switch_model.sv]
// Two reed contacts as seen at the comparator outputs.
// Assumes the bench commands each contact position.
module pcis_switch_model (
    input wire logic clock,
    input wire logic [1:0] position,
    input wire logic slow,
    output logic [1:0] contacts
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] lag [3];
    // A slow contact lags three samples, as a worn reed does
    always_ff @(posedge clock) begin
        lag <= '{position, lag[0], lag[1]};
    end
    assign contacts = slow ? lag[2] : position;
endmodule : pcis_switch_model

// [testbench/pulse_counter_input_status_tb.sv]
// Self-checking bench for the input status block.
// Assumes a 100 MHz sample clock and the switch model on the inputs.
module pulse_counter_input_status_tb
    import pcis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic sfr_wr = 1'h0, sfr_rd = 1'h0, rt_other_read = 1'h0, rt_update = 1'h0;
    logic pullup_duty_phase = 1'h0, slow = 1'h0, pulldown_on, pullup_on;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, high_debounce_count = 8'h03;
    logic [7:0] low_debounce_count = 8'h03, sfr_rdata, v;
    logic [1:0] counter_mode_select = 2'h0, pos = 2'h0, comparator_in;
    logic [1:0] high_threshold_select, low_threshold_select, integrator_out;
    logic [1:0] seq [2][4] = '{'{2'h1, 2'h3, 2'h2, 2'h0}, '{2'h2, 2'h3, 2'h1, 2'h0}};
    int mismatches = 0, n_tests = 0, cyc = 0;
    pcis_status #(.DEB_W(8)) DUT (.clock, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .rt_other_read, .rt_update, .comparator_in, .counter_mode_select,
        .high_debounce_count, .low_debounce_count, .pullup_duty_phase, .high_threshold_select,
        .low_threshold_select, .pulldown_on, .pullup_on, .integrator_out);
    pcis_switch_model reeds (.clock, .position(pos), .slow, .contacts(comparator_in));
    always #5 clock = ~clock;
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        @(negedge clock);
        sfr_wr = 1'h0;
    endtask : wr
    // Read data stands for one cycle only, so it is taken right after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr_addr = a;
        sfr_rd = 1'h1;
        @(negedge clock);
        sfr_rd = 1'h0;
        d = sfr_rdata;
    endtask : rd
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(negedge clock);
        reset = 1'h0;
        rd(8'hE4, v);
        chk("thresh reset", 8'h01, v);
        rd(8'h55, v);
        chk("unmapped", 8'h00, v);
        wr(8'hC1, 8'hFF);
        rd(8'hC1, v);
        chk("status reset", 8'h00, v);
        for (int i = 0; i < 4; i++) begin
            wr(8'hE4, {2'(i), 2'(i), 4'h0});
            chk("hi sel", 8'(i), 8'(high_threshold_select));
            chk("lo sel", 8'(i), 8'(low_threshold_select));
        end
        wr(8'hE4, 8'hF2);
        rd(8'hE4, v);
        chk("reserved", 8'hF1, v);
        // Every pull combination in both duty phases
        for (int i = 0; i < 8; i++) begin
            pullup_duty_phase = i[0];
            wr(8'hE4, {4'h0, 2'(i >> 1), 2'h0});
            chk("pull down", 8'(i[2]), 8'(pulldown_on));
            chk("pull up", 8'(!i[2] && i[1:0] != 0), 8'(pullup_on));
        end
        @(negedge clock);
        rt_other_read = 1'h1;
        rt_update = 1'h1;
        @(negedge clock);
        rt_other_read = 1'h0;
        rt_update = 1'h0;
        rd(8'hE4, v);
        chk("invalid", 8'h00, v & 8'h01);
        rd(8'hE4, v);
        chk("restored", 8'h01, v & 8'h01);
        rt_update = 1'h1;
        rd(8'hC1, v);
        rt_update = 1'h0;
        rd(8'hE4, v);
        chk("status clash", 8'h00, v & 8'h01);
        rt_update = 1'h1;
        @(negedge clock);
        rt_update = 1'h0;
        rd(8'hE4, v);
        chk("update alone", 8'h01, v & 8'h01);
        counter_mode_select = 2'h3;
        // One turn each way, the second with slow contacts
        for (int d = 0; d < 2; d++) begin
            slow = d[0];
            for (int s = 0; s < 4; s++) begin
                pos = seq[d][s];
                // Three sync flops, one agreement sample, then value plus one counts
                repeat (7 + 3 * d) @(negedge clock);
                chk("debounce", 8'(seq[d][(s + 3) % 4]), 8'(integrator_out));
                @(negedge clock);
                chk("debounced", 8'(seq[d][s]), 8'(integrator_out));
                repeat (10 - 3 * d) @(negedge clock);
                rd(8'hC1, v);
                chk("quad", {1'h0, d[0], {3{pos}}}, v);
            end
        end
        // Input 0 alone bounces twice
        for (int k = 0; k < 4; k++) begin
            pos = {1'h0, !k[0]};
            repeat (18) @(negedge clock);
        end
        rd(8'hC1, v);
        chk("flutter", 8'h80, v & 8'h80);
        counter_mode_select = 2'h0;
        repeat (4) @(negedge clock);
        rd(8'hC1, v);
        chk("flutter off", 8'h00, v & 8'h80);
        // Dual mode counts but tracks no flutter
        counter_mode_select = 2'h2;
        pos = 2'h1;
        repeat (18) @(negedge clock);
        rd(8'hC1, v);
        chk("dual mode", 8'h15, v & 8'hBF);
        give_verdict();
    end
endmodule : pulse_counter_input_status_tb
